// ===== rtl/bls_cond.sv
`timescale 1ns/1ns
`default_nettype none
module bls_cond
   import bls_pkg::*;
(
   input wire bls_pkg::bls_cmd_type cmd,
   input wire logic [2:0] bit_sel,
   input wire logic [7:0] flags,
   output logic is_branch,
   output logic taken
);

   always_comb begin
      is_branch = 1'b1;
      taken = 1'b0;
      case (cmd)
         CMD_BRANCH_ON_SELECTED_BIT_CLEAR: taken = ~flags[bit_sel]; // [RQ1]
         CMD_BRANCH_ON_EQUAL: taken = flags[FLAG_Z]; // [RQ2]
         CMD_BRANCH_ON_NOT_EQUAL: taken = ~flags[FLAG_Z]; // [RQ2]
         CMD_BRANCH_ON_CARRY_SET: taken = flags[FLAG_C]; // [RQ3]
         CMD_BRANCH_UNSIGNED_LOWER: taken = flags[FLAG_C]; // [RQ3]
         CMD_BRANCH_ON_CARRY_CLEAR: taken = ~flags[FLAG_C]; // [RQ3]
         CMD_BRANCH_UNSIGNED_SAME_OR_HIGHER: taken = ~flags[FLAG_C]; // [RQ3]
         CMD_BRANCH_ON_MINUS: taken = flags[FLAG_N]; // [RQ4]
         CMD_BRANCH_ON_PLUS: taken = ~flags[FLAG_N]; // [RQ4]
         // computed from n and v directly, not from the stored sign flag
         CMD_BRANCH_SIGNED_GREATER_EQUAL: taken = ~(flags[FLAG_N] ^ flags[FLAG_V]); // [RQ5]
         CMD_BRANCH_SIGNED_LESS_THAN: taken = flags[FLAG_N] ^ flags[FLAG_V]; // [RQ5]
         CMD_BRANCH_HALF_CARRY_SET: taken = flags[FLAG_H]; // [RQ6]
         CMD_BRANCH_HALF_CARRY_CLEAR: taken = ~flags[FLAG_H]; // [RQ6]
         CMD_BRANCH_TRANSFER_BIT_SET: taken = flags[FLAG_T]; // [RQ7]
         CMD_BRANCH_TRANSFER_BIT_CLEAR: taken = ~flags[FLAG_T]; // [RQ7]
         CMD_BRANCH_OVERFLOW_SET: taken = flags[FLAG_V]; // [RQ8]
         CMD_BRANCH_OVERFLOW_CLEAR: taken = ~flags[FLAG_V]; // [RQ8]
         CMD_BRANCH_INTERRUPTS_ENABLED: taken = flags[FLAG_I]; // [RQ9]
         CMD_BRANCH_INTERRUPTS_DISABLED: taken = ~flags[FLAG_I]; // [RQ9]
         default: is_branch = 1'b0;
      endcase
   end

endmodule
`default_nettype wire

// ===== rtl/bls_exec.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [RQ1] selected-bit-clear branch jumps to pc+offset+1 when that flag is zero; flags untouched
// [RQ2] equal branch takes on zero flag one, not-equal on zero flag zero
// [RQ3] carry-set and lower branch on carry one; carry-clear and same-or-higher on zero
// [RQ4] minus branches on negative flag one, plus on negative flag zero
// [RQ5] signed greater-equal takes when n xor v is zero, less-than when one
// [RQ6] half-carry branches test the half-carry flag, set or cleared form
// [RQ7] transfer-bit branches test the transfer flag, set or cleared form
// [RQ8] overflow branches test the overflow flag, set or cleared form
// [RQ9] interrupt-state branches test the global interrupt enable flag
// [RQ10] indirect load reads memory at the pointer; post-increment then bumps it; two cycles
// [RQ11] pre-decrement load lowers the pointer first, then reads at the new address
// [RQ12] displacement load reads at second or third pointer plus q, pointer kept
// [RQ13] indirect store writes the source at the pointer; post-increment bumps it after
// [RQ14] pre-decrement store lowers the pointer first, then writes at the new address
// [RQ15] displacement store writes at second or third pointer plus q, pointer kept
// [RQ16] direct load reads memory at the immediate address into the destination
// [RQ17] direct store writes the source to memory at the immediate address
// [RQ18] branch offset is signed; untaken branch advances to the next instruction
module bls_exec
   import bls_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire bls_pkg::bls_cmd_type cmd,
   input wire bls_pkg::bls_mode_type cmd_mode,
   input wire logic [1:0] cmd_ptr,
   input wire logic [2:0] cmd_bit,
   input wire logic [4:0] cmd_reg,
   input wire logic [5:0] cmd_disp,
   input wire logic [6:0] cmd_offset,
   input wire logic [15:0] cmd_addr,
   input wire logic [15:0] cmd_pc,
   input wire logic [7:0] flags,
   input wire logic [7:0] src_data,
   input wire logic [15:0] ptr_first,
   input wire logic [15:0] ptr_second,
   input wire logic [15:0] ptr_third,
   output logic pc_valid,
   output logic [15:0] pc_value,
   output logic done,
   output logic dm_re,
   output logic dm_we,
   output logic [15:0] dm_addr,
   output logic [7:0] dm_wdata,
   input wire logic [7:0] dm_rdata,
   output logic rf_we,
   output logic [4:0] rf_waddr,
   output logic [7:0] rf_wdata,
   output logic ptr_we,
   output logic [1:0] ptr_wsel,
   output logic [15:0] ptr_wdata,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   import bls_pkg::*;

   bls_state_type state;
   bls_state_type next_state;
   logic is_branch;
   logic taken;
   logic accept;
   logic is_load;
   logic is_store;
   logic is_mem;
   logic ptr_update;
   logic [15:0] sel_ptr;
   logic [15:0] eff_addr;
   logic [15:0] next_ptr;
   logic [15:0] branch_target;
   logic [5:0] disp_used;
   logic load_pending;
   logic store_pending;
   logic ctrl_enable;
   logic last_taken;
   logic [15:0] branch_count;
   logic bus_write;

   bls_cond u_cond (
      .cmd(cmd),
      .bit_sel(cmd_bit),
      .flags(flags),
      .is_branch(is_branch),
      .taken(taken)
   );

   assign accept = cmd_valid & cmd_ready;
   assign is_load = (cmd == CMD_INDIRECT_LOAD) | (cmd == CMD_DISPLACEMENT_LOAD)
                    | (cmd == CMD_DIRECT_LOAD);
   assign is_store = (cmd == CMD_INDIRECT_STORE) | (cmd == CMD_DISPLACEMENT_STORE)
                     | (cmd == CMD_DIRECT_STORE);
   assign is_mem = is_load | is_store;

   always_comb begin
      case (cmd_ptr)
         PTR_FIRST: sel_ptr = ptr_first;
         PTR_SECOND: sel_ptr = ptr_second;
         default: sel_ptr = ptr_third;
      endcase
   end

   // the first pair has no displacement form, so q is dropped for it
   assign disp_used = (cmd_ptr == PTR_FIRST) ? 6'h00 : cmd_disp; // [RQ12] [RQ15]

   // offset sign-extended, so backward branches wrap correctly
   assign branch_target = cmd_pc + {{9{cmd_offset[6]}}, cmd_offset} + 16'h0001; // [RQ18] [RQ1]

   always_comb begin
      eff_addr = sel_ptr;
      next_ptr = sel_ptr;
      ptr_update = 1'b0;
      case (cmd)
         CMD_INDIRECT_LOAD, CMD_INDIRECT_STORE: begin
            if (cmd_mode == MODE_PRE_DEC) begin
               eff_addr = sel_ptr - 16'h0001; // [RQ11] [RQ14]
               next_ptr = sel_ptr - 16'h0001;
               ptr_update = 1'b1;
            end else if (cmd_mode == MODE_POST_INC) begin
               next_ptr = sel_ptr + 16'h0001; // [RQ10] [RQ13]
               ptr_update = 1'b1;
            end
         end
         CMD_DISPLACEMENT_LOAD, CMD_DISPLACEMENT_STORE:
            eff_addr = sel_ptr + {10'h000, disp_used}; // [RQ12] [RQ15]
         CMD_DIRECT_LOAD, CMD_DIRECT_STORE: eff_addr = cmd_addr; // [RQ16] [RQ17]
         default: eff_addr = sel_ptr;
      endcase
   end

   always_comb begin
      next_state = STATE_IDLE;
      case (state)
         STATE_IDLE: begin
            // memory ops and taken branches own a second cycle
            if (accept && (is_mem || (is_branch && taken))) begin
               next_state = STATE_SECOND; // [RQ1] [RQ10] [RQ13]
            end
         end
         STATE_SECOND: next_state = STATE_IDLE;
         default: next_state = STATE_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= STATE_IDLE;
         cmd_ready <= 1'b0;
      end else begin
         state <= next_state;
         cmd_ready <= ctrl_enable & (next_state == STATE_IDLE);
      end
   end

   // program counter result; no flag output exists, so flags stay untouched
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pc_valid <= 1'b0;
         pc_value <= 16'h0000;
      end else begin
         pc_valid <= 1'b0;
         if (accept && is_branch) begin
            pc_value <= taken ? branch_target : cmd_pc + 16'h0001; // [RQ18] [RQ1]
            pc_valid <= ~taken; // [RQ18]
         end else if (state == STATE_SECOND && !load_pending && !store_pending) begin
            pc_valid <= 1'b1; // [RQ2] [RQ3] [RQ4] [RQ5] [RQ6] [RQ7] [RQ8] [RQ9]
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dm_re <= 1'b0;
         dm_we <= 1'b0;
         dm_addr <= 16'h0000;
         dm_wdata <= 8'h00;
         ptr_we <= 1'b0;
         ptr_wsel <= PTR_FIRST;
         ptr_wdata <= 16'h0000;
         load_pending <= 1'b0;
         store_pending <= 1'b0;
         rf_waddr <= 5'h00;
      end else begin
         dm_re <= accept & is_load; // [RQ10] [RQ16]
         dm_we <= accept & is_store; // [RQ13] [RQ17]
         ptr_we <= accept & ptr_update; // [RQ10] [RQ11] [RQ13] [RQ14]
         load_pending <= accept & is_load;
         store_pending <= accept & is_store;
         if (accept && is_mem) begin
            dm_addr <= eff_addr;
            dm_wdata <= src_data; // [RQ13] [RQ17]
            ptr_wsel <= cmd_ptr;
            ptr_wdata <= next_ptr;
            rf_waddr <= cmd_reg;
         end
      end
   end

   // asynchronous memory: read data is valid and sampled in the same cycle as dm_re
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rf_we <= 1'b0;
         rf_wdata <= 8'h00;
         done <= 1'b0;
      end else begin
         rf_we <= load_pending; // [RQ10] [RQ16]
         if (load_pending) begin
            rf_wdata <= dm_rdata;
         end
         done <= (accept && is_branch && !taken) || (accept && !is_branch && !is_mem)
                 || (state == STATE_SECOND);
      end
   end

   assign bus_write = avs_write & ~avs_waitrequest;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         if (!avs_waitrequest) begin
            avs_waitrequest <= 1'b1;
         end else if (avs_read || avs_write) begin
            avs_waitrequest <= 1'b0;
         end
         if (avs_read && avs_waitrequest) begin
            case (avs_address)
               REG_CTRL: avs_readdata <= {31'h0, ctrl_enable};
               REG_STATUS: avs_readdata <= {30'h0, last_taken, state == STATE_SECOND};
               REG_BRANCH_COUNT: avs_readdata <= {16'h0000, branch_count};
               default: avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_enable <= CTRL_ENABLE_RESET;
      end else if (bus_write && avs_address == REG_CTRL) begin
         ctrl_enable <= avs_writedata[CTRL_ENABLE_BIT];
      end
   end

   // a taken branch in the clearing cycle still counts
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         branch_count <= BRANCH_COUNT_RESET;
         last_taken <= 1'b0;
      end else begin
         if (bus_write && avs_address == REG_BRANCH_COUNT) begin
            branch_count <= (accept && is_branch && taken) ? 16'h0001 : BRANCH_COUNT_RESET;
         end else if (accept && is_branch && taken) begin
            branch_count <= branch_count + 16'h0001;
         end
         if (accept && is_branch) begin
            last_taken <= taken;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_untaken_next_pc: assert property ( // [RQ18]
      accept && is_branch && !taken |=> pc_valid && done && pc_value == $past(cmd_pc) + 16'h0001)
      else $error("untaken branch did not advance by one");
   a_taken_two_cycles: assert property ( // [RQ1]
      accept && is_branch && taken |=> !pc_valid && !cmd_ready ##1 pc_valid && done)
      else $error("taken branch did not finish in two cycles");
   a_equal_flag: assert property ( // [RQ2]
      cmd == CMD_BRANCH_ON_EQUAL |-> taken == flags[FLAG_Z])
      else $error("equal branch ignores zero flag");
   a_lower_carry: assert property ( // [RQ3]
      cmd == CMD_BRANCH_UNSIGNED_LOWER || cmd == CMD_BRANCH_ON_CARRY_SET
      |-> taken == flags[FLAG_C])
      else $error("carry branch wrong");
   a_plus_flag: assert property ( // [RQ4]
      cmd == CMD_BRANCH_ON_PLUS |-> taken != flags[FLAG_N])
      else $error("plus branch wrong");
   a_signed_ge: assert property ( // [RQ5]
      cmd == CMD_BRANCH_SIGNED_GREATER_EQUAL |-> taken == (flags[FLAG_N] == flags[FLAG_V]))
      else $error("signed ge branch wrong");
   a_load_result: assert property ( // [RQ10]
      accept && is_load |=> dm_re ##1 rf_we && done && rf_wdata == $past(dm_rdata))
      else $error("load did not write register in two cycles");
   a_pre_dec_addr: assert property ( // [RQ11]
      accept && cmd == CMD_INDIRECT_LOAD && cmd_mode == MODE_PRE_DEC
      |=> ptr_we && dm_addr == $past(sel_ptr) - 16'h0001 && ptr_wdata == dm_addr)
      else $error("pre-decrement address wrong");
   a_disp_ptr_kept: assert property ( // [RQ12]
      accept && (cmd == CMD_DISPLACEMENT_LOAD || cmd == CMD_DISPLACEMENT_STORE)
      |=> !ptr_we && dm_addr == $past(eff_addr))
      else $error("displacement access touched pointer");
   a_direct_store: assert property ( // [RQ17]
      accept && cmd == CMD_DIRECT_STORE
      |=> dm_we && dm_addr == $past(cmd_addr) && dm_wdata == $past(src_data) ##1 done)
      else $error("direct store wrong");

   c_taken_branch: cover property (accept && is_branch && taken ##2 pc_valid);
   c_pre_dec_store: cover property (accept && cmd == CMD_INDIRECT_STORE && cmd_mode == MODE_PRE_DEC);
   c_load_done: cover property (accept && cmd == CMD_DIRECT_LOAD ##2 rf_we);
   c_bus_read: cover property (avs_read && !avs_waitrequest);

endmodule
`default_nettype wire

// ===== rtl/bls_pkg.sv
package bls_pkg;

   // bit positions inside the processor_flag_register
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   typedef enum logic [4:0] {
      CMD_NOP                            = 5'h00,
      CMD_BRANCH_ON_SELECTED_BIT_CLEAR   = 5'h01,
      CMD_BRANCH_ON_EQUAL                = 5'h02,
      CMD_BRANCH_ON_NOT_EQUAL            = 5'h03,
      CMD_BRANCH_ON_CARRY_SET            = 5'h04,
      CMD_BRANCH_ON_CARRY_CLEAR          = 5'h05,
      CMD_BRANCH_UNSIGNED_SAME_OR_HIGHER = 5'h06,
      CMD_BRANCH_UNSIGNED_LOWER          = 5'h07,
      CMD_BRANCH_ON_MINUS                = 5'h08,
      CMD_BRANCH_ON_PLUS                 = 5'h09,
      CMD_BRANCH_SIGNED_GREATER_EQUAL    = 5'h0a,
      CMD_BRANCH_SIGNED_LESS_THAN        = 5'h0b,
      CMD_BRANCH_HALF_CARRY_SET          = 5'h0c,
      CMD_BRANCH_HALF_CARRY_CLEAR        = 5'h0d,
      CMD_BRANCH_TRANSFER_BIT_SET        = 5'h0e,
      CMD_BRANCH_TRANSFER_BIT_CLEAR      = 5'h0f,
      CMD_BRANCH_OVERFLOW_SET            = 5'h10,
      CMD_BRANCH_OVERFLOW_CLEAR          = 5'h11,
      CMD_BRANCH_INTERRUPTS_ENABLED      = 5'h12,
      CMD_BRANCH_INTERRUPTS_DISABLED     = 5'h13,
      CMD_INDIRECT_LOAD                  = 5'h14,
      CMD_DISPLACEMENT_LOAD              = 5'h15,
      CMD_DIRECT_LOAD                    = 5'h16,
      CMD_INDIRECT_STORE                 = 5'h17,
      CMD_DISPLACEMENT_STORE             = 5'h18,
      CMD_DIRECT_STORE                   = 5'h19
   } bls_cmd_type;

   typedef enum logic [1:0] {
      MODE_PLAIN    = 2'h0,
      MODE_POST_INC = 2'h1,
      MODE_PRE_DEC  = 2'h2
   } bls_mode_type;

   typedef enum logic [0:0] {
      STATE_IDLE = 1'h0,
      STATE_SECOND = 1'h1
   } bls_state_type;

   localparam logic [1:0] PTR_FIRST = 2'h0;
   localparam logic [1:0] PTR_SECOND = 2'h1;
   localparam logic [1:0] PTR_THIRD = 2'h2;

   // register map, byte addresses
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_BRANCH_COUNT = 4'h8;

   localparam int CTRL_ENABLE_BIT = 0;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_LAST_TAKEN_BIT = 1;
   localparam logic CTRL_ENABLE_RESET = 1'h1;
   localparam logic [15:0] BRANCH_COUNT_RESET = 16'h0000;

endpackage

// ===== sim/bls_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module bls_mem_model (
   input wire logic clk,
   input wire logic dm_re,
   input wire logic dm_we,
   input wire logic [15:0] dm_addr,
   input wire logic [7:0] dm_wdata,
   output logic [7:0] dm_rdata
);
   logic [7:0] mem [0:255];
   logic [7:0] last;
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'h5a;
      end
      last = 8'h00;
   end
   // only the low byte decodes; the bench's pre-decrement of the first pointer from 0x0000 wraps to 0xffff, which aliases 0xff
   always @(posedge clk) begin
      if (dm_we) begin
         mem[dm_addr[7:0]] <= dm_wdata;
      end
      if (dm_re) begin
         last <= mem[dm_addr[7:0]];
      end
   end
   // no read in flight: show the inverse so a late sample cannot match by luck
   assign dm_rdata = dm_re ? mem[dm_addr[7:0]] : ~last;
endmodule
`default_nettype wire

// ===== sim/branch_and_load_store_exec_test.sv
`timescale 1ns/1ns
`default_nettype none
module branch_and_load_store_exec_test;
   import bls_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cmd_valid = 1'b0;
   bls_cmd_type cmd = CMD_NOP;
   bls_mode_type cmd_mode = MODE_PLAIN;
   logic [1:0] cmd_ptr = 2'h0;
   logic [2:0] cmd_bit = 3'h0;
   logic [4:0] cmd_reg = 5'h00;
   logic [5:0] cmd_disp = 6'h00;
   logic [6:0] cmd_offset = 7'h00;
   logic [15:0] cmd_addr = 16'h0000;
   logic [15:0] cmd_pc = 16'h0000;
   logic [7:0] flags = 8'h00;
   logic [7:0] src_data = 8'h00;
   logic [15:0] ptr_first = 16'h0000;
   logic [15:0] ptr_second = 16'h0040;
   logic [15:0] ptr_third = 16'h00c0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic cmd_ready, pc_valid, done, dm_re, dm_we, rf_we, ptr_we, avs_waitrequest;
   logic [15:0] pc_value, dm_addr, ptr_wdata;
   logic [7:0] dm_wdata, dm_rdata, rf_wdata;
   logic [4:0] rf_waddr;
   logic [1:0] ptr_wsel;
   logic [31:0] avs_readdata;
   int fail_count = 0;
   int compares = 0;
   int lat;
   int ntaken = 0;
   bit last_tk = 1'b0;
   logic s_pcv, s_dmre, s_dmwe, s_rfwe, s_ptrwe;
   logic [15:0] s_pc, s_addr, s_ptrdata;
   logic [7:0] s_wdata, s_rfdata;
   logic [4:0] s_rfaddr;
   logic [1:0] s_ptrsel;
   logic [7:0] exp_mem [0:255];

   bls_exec u_dut (.clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd, .cmd_mode, .cmd_ptr, .cmd_bit,
      .cmd_reg, .cmd_disp, .cmd_offset, .cmd_addr, .cmd_pc, .flags, .src_data, .ptr_first,
      .ptr_second, .ptr_third, .pc_valid, .pc_value, .done, .dm_re, .dm_we, .dm_addr,
      .dm_wdata, .dm_rdata, .rf_we, .rf_waddr, .rf_wdata, .ptr_we, .ptr_wsel, .ptr_wdata,
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
   bls_mem_model u_mem (.clk, .dm_re, .dm_we, .dm_addr, .dm_wdata, .dm_rdata);

   always #2 clk = ~clk;

   task automatic complete_run();
      $display("counts: %0d compares, %0d mismatches", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic miss(input string msg);
      fail_count++;
      $display("wrong value at %0t: %s", $time, msg);
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string msg);
      compares++;
      if (got !== exp) miss(msg);
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
      compares++;
      if (got !== exp) miss($sformatf("%s got %h want %h", msg, got, exp));
   endtask
   task automatic chk_count(input int got, input int exp, input string msg);
      compares++;
      if (got != exp) miss($sformatf("%s got %0d want %0d", msg, got, exp));
   endtask

   // caller stands at a rising edge with the command fields already scheduled
   task automatic fire();
      int n;
      n = 0;
      cmd_valid <= 1'b1;
      #1;
      while (cmd_ready !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 20) miss("command never accepted");
      @(posedge clk);
      cmd_valid <= 1'b0;
      {s_pcv, s_dmre, s_dmwe, s_rfwe, s_ptrwe} = 5'h00;
      lat = 0;
      for (int k = 1; k <= 4 && lat == 0; k++) begin
         #1;
         if (pc_valid === 1'b1) {s_pcv, s_pc} = {1'b1, pc_value};
         if (dm_re === 1'b1) {s_dmre, s_addr} = {1'b1, dm_addr};
         if (dm_we === 1'b1) {s_dmwe, s_addr, s_wdata} = {1'b1, dm_addr, dm_wdata};
         if (rf_we === 1'b1) {s_rfwe, s_rfaddr, s_rfdata} = {1'b1, rf_waddr, rf_wdata};
         if (ptr_we === 1'b1) {s_ptrwe, s_ptrsel, s_ptrdata} = {1'b1, ptr_wsel, ptr_wdata};
         if (done === 1'b1) lat = k;
         else @(posedge clk);
      end
   endtask

   function automatic bit exp_taken(input bls_cmd_type c, input logic [2:0] b,
         input logic [7:0] f);
      case (c)
         CMD_BRANCH_ON_SELECTED_BIT_CLEAR: return !f[b];
         CMD_BRANCH_ON_EQUAL: return f[FLAG_Z];
         CMD_BRANCH_ON_NOT_EQUAL: return !f[FLAG_Z];
         CMD_BRANCH_ON_CARRY_SET, CMD_BRANCH_UNSIGNED_LOWER: return f[FLAG_C];
         CMD_BRANCH_ON_CARRY_CLEAR, CMD_BRANCH_UNSIGNED_SAME_OR_HIGHER: return !f[FLAG_C];
         CMD_BRANCH_ON_MINUS: return f[FLAG_N];
         CMD_BRANCH_ON_PLUS: return !f[FLAG_N];
         CMD_BRANCH_SIGNED_GREATER_EQUAL: return !(f[FLAG_N] ^ f[FLAG_V]);
         CMD_BRANCH_SIGNED_LESS_THAN: return f[FLAG_N] ^ f[FLAG_V];
         CMD_BRANCH_HALF_CARRY_SET: return f[FLAG_H];
         CMD_BRANCH_HALF_CARRY_CLEAR: return !f[FLAG_H];
         CMD_BRANCH_TRANSFER_BIT_SET: return f[FLAG_T];
         CMD_BRANCH_TRANSFER_BIT_CLEAR: return !f[FLAG_T];
         CMD_BRANCH_OVERFLOW_SET: return f[FLAG_V];
         CMD_BRANCH_OVERFLOW_CLEAR: return !f[FLAG_V];
         CMD_BRANCH_INTERRUPTS_ENABLED: return f[FLAG_I];
         default: return !f[FLAG_I];
      endcase
   endfunction

   // every branch code against single flags except T, all-clear, all-set and n/v mixes
   task automatic test_branches();
      logic [7:0] pats [10] = '{8'h00, 8'hff, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20,
         8'h0c, 8'h80};
      logic [6:0] off;
      logic [15:0] pc, tgt;
      bls_cmd_type c;
      for (int ci = 1; ci <= 19; ci++) begin
         for (int i = 0; i < 10; i++) begin
            c = bls_cmd_type'(5'(ci));
            off = i[0] ? 7'h7d : 7'h05;
            pc = (ci == 19 && i == 9) ? 16'hfffd : 16'h0100 + 16'(ci);
            last_tk = exp_taken(c, 3'(i), pats[i]);
            ntaken += last_tk;
            tgt = pc + 16'h1 + (last_tk ? {{9{off[6]}}, off} : 16'h0);
            @(posedge clk);
            cmd <= c;
            cmd_bit <= 3'(i);
            flags <= pats[i];
            cmd_offset <= off;
            cmd_pc <= pc;
            fire();
            chk_count(lat, last_tk ? 2 : 1, "branch cycles");
            chk_bit(s_pcv, 1'b1, "branch pc strobe");
            chk_word(s_pc, tgt, "branch target");
            chk_bit(s_dmre | s_dmwe | s_rfwe | s_ptrwe, 1'b0, "branch side effect");
         end
      end
      $display("test branches done");
   endtask

   // stores first, then loads read the same places back through every mode
   task automatic test_memory();
      logic [15:0] p, a;
      logic [1:0] ps;
      logic [7:0] dat;
      logic [15:0] np;
      bls_mode_type md;
      for (int wr = 1; wr >= 0; wr--) begin
         for (int k = 0; k < 13; k++) begin
            ps = (k < 9) ? 2'(k / 3) : 2'(k - 9);
            md = (k < 9) ? bls_mode_type'(2'(k % 3)) : MODE_PLAIN;
            p = ps == 2'h0 ? ptr_first : ps == 2'h1 ? ptr_second : ptr_third;
            a = (md == MODE_PRE_DEC) ? p - 16'h1 : p;
            if (k >= 9 && ps != 2'h0) a = p + {10'h0, 6'(k + 30)};
            if (k == 12) a = 16'h0087;
            dat = 8'(8'h30 + k);
            np = (md == MODE_PRE_DEC) ? p - 16'h1 : p + 16'h1;
            @(posedge clk);
            cmd <= bls_cmd_type'(5'(20 + 3 * wr + (k >= 9) + (k == 12)));
            cmd_mode <= md;
            cmd_ptr <= ps;
            cmd_disp <= 6'(k + 30);
            cmd_addr <= 16'h0087;
            cmd_reg <= 5'(k);
            src_data <= dat;
            fire();
            chk_count(lat, 2, "transfer cycles");
            chk_word(s_addr, a, "memory address");
            chk_bit(s_dmre, wr == 0, "read strobe");
            chk_bit(s_dmwe, wr == 1, "write strobe");
            chk_bit(s_rfwe, wr == 0, "register write");
            chk_bit(s_ptrwe, md != MODE_PLAIN, "pointer write");
            if (md != MODE_PLAIN) begin
               chk_word(s_ptrsel, ps, "pointer select");
               chk_word(s_ptrdata, np, "pointer");
            end
            if (wr == 1) begin
               chk_word(s_wdata, dat, "store data");
               exp_mem[a[7:0]] = dat;
            end else begin
               chk_word(s_rfaddr, k, "load register");
               chk_word(s_rfdata, exp_mem[a[7:0]], "load data");
            end
         end
      end
      $display("test memory done");
   endtask

   task automatic av_xfer(input bit wr, input logic [3:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= wd;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) miss("bus wait never ended");
      // waitrequest is low across this edge: the write lands here and read data is taken here
      @(posedge clk);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic test_regs();
      logic [31:0] rd;
      av_xfer(0, REG_CTRL, 32'h0, rd);
      chk_word(rd, 32'h1, "ctrl reset");
      // end on a taken branch so the last-taken status bit differs from its reset value
      @(posedge clk);
      cmd <= CMD_BRANCH_ON_EQUAL;
      flags <= 8'h02;
      fire();
      chk_count(lat, 2, "taken before status");
      ntaken++;
      last_tk = 1'b1;
      av_xfer(0, REG_BRANCH_COUNT, 32'h0, rd);
      chk_word(rd, 32'(ntaken), "taken count");
      av_xfer(0, REG_STATUS, 32'h0, rd);
      chk_word(rd, {30'h0, last_tk, 1'b0}, "status");
      av_xfer(1, REG_BRANCH_COUNT, 32'h5, rd);
      av_xfer(0, REG_BRANCH_COUNT, 32'h0, rd);
      chk_word(rd, 32'h0, "count cleared");
      av_xfer(1, 4'hc, 32'h0, rd);
      av_xfer(0, 4'hc, 32'h0, rd);
      chk_word(rd, 32'h0, "unmapped read");
      av_xfer(1, REG_CTRL, 32'h0, rd);
      av_xfer(0, REG_CTRL, 32'h0, rd);
      chk_word(rd, 32'h0, "ctrl written");
      @(posedge clk);
      cmd <= CMD_NOP;
      cmd_valid <= 1'b1;
      repeat (6) begin
         @(posedge clk);
         #1;
         chk_bit(cmd_ready | done, 1'b0, "disabled block took a command");
      end
      @(posedge clk);
      cmd_valid <= 1'b0;
      av_xfer(1, REG_CTRL, 32'h1, rd);
      @(posedge clk);
      fire();
      chk_count(lat, 1, "nop after enable");
      $display("test registers done");
   endtask

   initial begin
      for (int i = 0; i < 256; i++) begin
         exp_mem[i] = 8'(i) ^ 8'h5a;
      end
      repeat (15) @(posedge clk);
      #1;
      chk_bit(cmd_ready | ~avs_waitrequest, 1'b0, "reset outputs");
      @(posedge clk);
      sys_rst <= 1'b0;
      test_branches();
      test_memory();
      test_regs();
      complete_run();
   end

   // the whole run needs well under a thousand cycles; this leaves ample margin
   initial begin
      #200000;
      miss("watchdog expired");
      complete_run();
   end
endmodule
`default_nettype wire
